// ==== pkg/irq_agg_pkg.sv ====
// Purpose: constants for the streaming controller interrupt aggregator
// Assumes: single clock, synchronous active-low reset
// Notes: bus-event bit order is fixed below and shared by all files that import irq_agg_pkg
package irq_agg_pkg;
    // ************************************************
    // Sizes and bus-event bit positions
    // ************************************************
    localparam int NUM_EP = 8;
    localparam int NUM_BUS_EV = 7;
    localparam int BUS_EV_FUNC_RESET = 0;
    localparam int BUS_EV_SUSPEND = 1;
    localparam int BUS_EV_RESUME = 2;
    localparam int BUS_EV_FRAME_START = 3;
    localparam int BUS_EV_PSEUDO_FRAME_START = 4;
    localparam int BUS_EV_SETUP_RCVD = 5;
    localparam int BUS_EV_SETUP_OVERWRITE = 6;
    // ************************************************
    // Data-register sources
    // ************************************************
    localparam int NUM_DREG = 4;
    localparam int DREG_AUDIO_TX_EMPTY = 0;
    localparam int DREG_AUDIO_RX_FULL = 1;
    localparam int DREG_TWI_TX_EMPTY = 2;
    localparam int DREG_TWI_RX_FULL = 3;
    // ************************************************
    // Reset values
    // ************************************************
    localparam logic RST_FLAG = 1'h0;
    localparam logic RST_SYNC = 1'h1;
endpackage : irq_agg_pkg

// ==== logic/sticky_flag.sv ====
// Purpose: one sticky pending flag, set by hardware, cleared by firmware
// Assumes: set and clear are single-cycle pulses on clk_i
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
module sticky_flag
    import irq_agg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'h0;
        end
        if (set_i) begin
            flag_d = 1'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flag_q <= RST_FLAG;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule : sticky_flag

// ==== logic/usb_streaming_irq_aggregator.sv ====
// Purpose: merge on-chip event sources into the core's external interrupt 0
// Assumes: event pulses come from logic on clk_i; the external pin is async
// Notes: external pin is active low; no status bit is kept for it
`timescale 1ns/1ps
// How it works
// - Every extra source is ORed into one request on the core's external interrupt 0.
// - Sources are 8 in and 8 out endpoints, seven bus events, four data-register events, the pin.
// - The core keeps its four other sources; timers and serial pass untouched, external 1 goes through a two-flop synchroniser.
// - Endpoint interrupts have no mask and always reach the request.
// - An endpoint interrupt is raised only at the end of a successful transaction.
// - Each endpoint has a read-only status bit for diagnostics.
// - Endpoint interrupt and status stay asserted until firmware clears the interrupt.
// - Each bus event is individually maskable and has its own read-only status bit.
// - Bus-event interrupt and status stay asserted until firmware clears the interrupt.
// - Audio port and two-wire data-register events are each maskable with a status bit.
// - Clearing a data-register interrupt leaves its status bit untouched.
// - The external pin joins the request only while its global enable bit is set.
// - The external pin has no status bit.
// - Isochronous transactions never raise an endpoint interrupt.
module usb_streaming_irq_aggregator
    import irq_agg_pkg::*;
#(
    parameter int EPS = NUM_EP
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Endpoint transaction completion
    input wire logic [EPS-1:0] in_ep_done_i,
    input wire logic [EPS-1:0] in_ep_ok_i,
    input wire logic [EPS-1:0] in_ep_iso_i,
    input wire logic [EPS-1:0] out_ep_done_i,
    input wire logic [EPS-1:0] out_ep_ok_i,
    input wire logic [EPS-1:0] out_ep_iso_i,
    input wire logic [EPS-1:0] in_ep_clr_i,
    input wire logic [EPS-1:0] out_ep_clr_i,
    // Bus events
    input wire logic [NUM_BUS_EV-1:0] bus_ev_i,
    input wire logic [NUM_BUS_EV-1:0] bus_ev_mask_i,
    input wire logic [NUM_BUS_EV-1:0] bus_ev_clr_i,
    // Data-register conditions
    input wire logic [NUM_DREG-1:0] dreg_cond_i,
    input wire logic [NUM_DREG-1:0] dreg_mask_i,
    input wire logic [NUM_DREG-1:0] dreg_clr_i,
    // External pin
    input wire logic external_irq_pin_b_i,
    input wire logic ext_irq_en_i,
    // Core's own sources
    input wire logic core_ext_irq_one_b_i,
    input wire logic timer0_irq_i,
    input wire logic timer1_irq_i,
    input wire logic serial_irq_i,
    // To the core
    output logic core_ext_irq_zero_b_o,
    output logic core_ext_irq_one_b_o,
    output logic timer0_irq_o,
    output logic timer1_irq_o,
    output logic serial_irq_o,
    // Status
    output logic [EPS-1:0] in_ep_status_o,
    output logic [EPS-1:0] out_ep_status_o,
    output logic [NUM_BUS_EV-1:0] bus_ev_status_o,
    output logic [NUM_DREG-1:0] dreg_status_o,
    output logic [NUM_DREG-1:0] dreg_pend_o
);
    // ************************************************
    // Endpoint and bus-event flags
    // ************************************************
    logic [EPS-1:0] in_set;
    logic [EPS-1:0] out_set;
    logic [EPS-1:0] in_pend;
    logic [EPS-1:0] out_pend;
    logic [NUM_BUS_EV-1:0] bus_pend;
    logic [NUM_DREG-1:0] dreg_pend;
    logic [NUM_DREG-1:0] dreg_rise;

    // Isochronous endpoints are serviced by DMA, never the core
    assign in_set = in_ep_done_i & in_ep_ok_i & ~in_ep_iso_i;
    assign out_set = out_ep_done_i & out_ep_ok_i & ~out_ep_iso_i;

    for (genvar g = 0; g < EPS; g++) begin : g_ep
        sticky_flag u_in (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .set_i(in_set[g]),
            .clr_i(in_ep_clr_i[g]),
            .flag_o(in_pend[g])
        );
        sticky_flag u_out (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .set_i(out_set[g]),
            .clr_i(out_ep_clr_i[g]),
            .flag_o(out_pend[g])
        );
    end

    for (genvar g = 0; g < NUM_BUS_EV; g++) begin : g_bus
        sticky_flag u_bus (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .set_i(bus_ev_i[g]),
            .clr_i(bus_ev_clr_i[g]),
            .flag_o(bus_pend[g])
        );
    end

    // ************************************************
    // Data-register pending (set on condition rise)
    // ************************************************
    logic [NUM_DREG-1:0] dreg_cond_q;
    logic [NUM_DREG-1:0] dreg_cond_d;

    always_comb begin
        dreg_cond_d = dreg_cond_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dreg_cond_q <= '0;
        end else begin
            dreg_cond_q <= dreg_cond_d;
        end
    end

    assign dreg_rise = dreg_cond_i & ~dreg_cond_q;

    for (genvar g = 0; g < NUM_DREG; g++) begin : g_dreg
        sticky_flag u_dreg (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .set_i(dreg_rise[g]),
            .clr_i(dreg_clr_i[g]),
            .flag_o(dreg_pend[g])
        );
    end

    // ************************************************
    // External pin and external 1 synchronisers
    // ************************************************
    logic [1:0] pin_sync_q;
    logic [1:0] pin_sync_d;
    logic [1:0] one_sync_q;
    logic [1:0] one_sync_d;

    always_comb begin
        pin_sync_d = {pin_sync_q[0], external_irq_pin_b_i};
        one_sync_d = {one_sync_q[0], core_ext_irq_one_b_i};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pin_sync_q <= {2{RST_SYNC}};
            one_sync_q <= {2{RST_SYNC}};
        end else begin
            pin_sync_q <= pin_sync_d;
            one_sync_q <= one_sync_d;
        end
    end

    // ************************************************
    // Combined request, registered
    // ************************************************
    logic req_d;
    logic req_q;
    logic ext_live;

    // No pending flag for the pin: its synchronised level is seen only through the request
    assign ext_live = ext_irq_en_i & ~pin_sync_q[1];

    always_comb begin
        req_d = (|in_pend) | (|out_pend)
            | (|(bus_pend & ~bus_ev_mask_i))
            | (|(dreg_pend & ~dreg_mask_i))
            | ext_live;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            req_q <= 1'h0;
        end else begin
            req_q <= req_d;
        end
    end

    assign core_ext_irq_zero_b_o = ~req_q;
    // Timers and serial pass straight through; external 1 comes from its synchroniser
    assign core_ext_irq_one_b_o = one_sync_q[1];
    assign timer0_irq_o = timer0_irq_i;
    assign timer1_irq_o = timer1_irq_i;
    assign serial_irq_o = serial_irq_i;

    assign in_ep_status_o = in_pend;
    assign out_ep_status_o = out_pend;
    assign bus_ev_status_o = bus_pend;
    // Status follows the condition registered one cycle late, so a clear cannot drop it
    assign dreg_status_o = dreg_cond_q;
    assign dreg_pend_o = dreg_pend;

    // ************************************************
    // Assertions
    // ************************************************
    property p_ep_req;
        @(posedge clk_i) disable iff (!rst_b_i)
            (|in_pend) |=> !core_ext_irq_zero_b_o;
    endproperty
    a_ep_req: assert property (p_ep_req) else $error("endpoint not on request");

    property p_ep_set;
        @(posedge clk_i) disable iff (!rst_b_i)
            out_set[0] |=> out_ep_status_o[0];
    endproperty
    a_ep_set: assert property (p_ep_set) else $error("endpoint flag not set");

    property p_iso;
        @(posedge clk_i) disable iff (!rst_b_i)
            (in_ep_iso_i[0] && !in_ep_status_o[0]) |=> !in_ep_status_o[0];
    endproperty
    a_iso: assert property (p_iso) else $error("iso raised endpoint irq");

    property p_ep_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
            (in_ep_status_o[0] && !in_ep_clr_i[0]) |=> in_ep_status_o[0];
    endproperty
    a_ep_hold: assert property (p_ep_hold) else $error("endpoint flag dropped");

    property p_bus_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
            (bus_ev_status_o[BUS_EV_SUSPEND] && !bus_ev_clr_i[BUS_EV_SUSPEND])
            |=> bus_ev_status_o[BUS_EV_SUSPEND];
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus flag dropped");

    property p_mask;
        @(posedge clk_i) disable iff (!rst_b_i)
            (in_pend == '0 && out_pend == '0 && (bus_pend & ~bus_ev_mask_i) == '0
             && (dreg_pend & ~dreg_mask_i) == '0 && !(ext_irq_en_i && !pin_sync_q[1]))
            |=> core_ext_irq_zero_b_o;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source on request");

    property p_dreg_stat;
        @(posedge clk_i) disable iff (!rst_b_i)
            (dreg_cond_i[0] && dreg_clr_i[0]) |=> dreg_status_o[0];
    endproperty
    a_dreg_stat: assert property (p_dreg_stat) else $error("data status cleared");

    property p_ext;
        @(posedge clk_i) disable iff (!rst_b_i)
            (ext_irq_en_i && !pin_sync_q[1]) |=> !core_ext_irq_zero_b_o;
    endproperty
    a_ext: assert property (p_ext) else $error("enabled pin not on request");

    c_ep: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        in_set[0] ##[1:10] in_ep_clr_i[0]);
    c_bus: cover property (@(posedge clk_i) disable iff (!rst_b_i) |(bus_pend & bus_ev_mask_i));
    c_ext: cover property (@(posedge clk_i) disable iff (!rst_b_i) ext_live);
endmodule : usb_streaming_irq_aggregator

// ==== sim/core_service_model.sv ====
// Purpose: core side that services the combined interrupt request
// Assumes: level-sensitive external interrupt 0, active low
// Notes: request must be seen low on two edges before it is taken
`timescale 1ns/1ps
module core_service_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Request from the aggregator
    input wire logic req_b_i,
    // Service state
    output logic taken_o
);
    logic low_q;
    logic low_d;
    logic taken_q;
    logic taken_d;
    // Two samples filter glitches, so a short request is never serviced
    always_comb begin
        low_d = !req_b_i;
        taken_d = low_q && !req_b_i;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            low_q <= 1'h0;
            taken_q <= 1'h0;
        end else begin
            low_q <= low_d;
            taken_q <= taken_d;
        end
    end
    assign taken_o = taken_q;
endmodule : core_service_model

// ==== sim/usb_streaming_irq_aggregator_tb.sv ====
// Purpose: self-checking bench for the interrupt aggregator
// Assumes: eight endpoints, inputs change 1 ns after the rising edge
// Notes: waits cover the two and three cycle latencies
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module usb_streaming_irq_aggregator_tb;
    import irq_agg_pkg::*;
    logic clk_i, rst_b_i, ext_en, pin_b, one_b_i, t0_i, t1_i, ser_i;
    logic zero_b, one_b, t0_o, t1_o, ser_o, taken;
    logic [NUM_EP-1:0] in_done, in_ok, in_iso, out_done, out_ok, out_iso, in_clr, out_clr;
    logic [NUM_EP-1:0] in_st, out_st;
    logic [NUM_BUS_EV-1:0] bus_ev, bus_mask, bus_clr, bus_st;
    logic [NUM_DREG-1:0] dcond, dmask, dclr, dst, dpend;
    int err_count = 0;
    int tests_run = 0;
    int i, p;
    usb_streaming_irq_aggregator dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .in_ep_done_i(in_done), .in_ep_ok_i(in_ok), .in_ep_iso_i(in_iso),
        .out_ep_done_i(out_done), .out_ep_ok_i(out_ok), .out_ep_iso_i(out_iso),
        .in_ep_clr_i(in_clr), .out_ep_clr_i(out_clr), .bus_ev_i(bus_ev),
        .bus_ev_mask_i(bus_mask), .bus_ev_clr_i(bus_clr), .dreg_cond_i(dcond),
        .dreg_mask_i(dmask), .dreg_clr_i(dclr), .external_irq_pin_b_i(pin_b),
        .ext_irq_en_i(ext_en), .core_ext_irq_one_b_i(one_b_i), .timer0_irq_i(t0_i),
        .timer1_irq_i(t1_i), .serial_irq_i(ser_i), .core_ext_irq_zero_b_o(zero_b),
        .core_ext_irq_one_b_o(one_b), .timer0_irq_o(t0_o), .timer1_irq_o(t1_o),
        .serial_irq_o(ser_o), .in_ep_status_o(in_st), .out_ep_status_o(out_st),
        .bus_ev_status_o(bus_st), .dreg_status_o(dst), .dreg_pend_o(dpend));
    core_service_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_b_i(zero_b),
        .taken_o(taken));
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task test_done;
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        err_count++;
        test_done();
    end
    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        {rst_b_i, ext_en, t0_i, t1_i, ser_i} = 5'h00;
        {pin_b, one_b_i} = 2'h3;
        {in_done, in_ok, in_iso, out_done, out_ok, out_iso, in_clr, out_clr} = '0;
        {bus_ev, bus_mask, bus_clr, dcond, dmask, dclr} = '0;
        cyc(10);
        rst_b_i = 1'h1;
        cyc(1);
        `CHK({zero_b, in_st, out_st, bus_st, dpend}, 28'h8000000);
        for (i = 0; i < NUM_EP; i++) begin
            // Pass 0 in taken, 1 out taken, 2 both refused
            for (p = 0; p < 3; p++) begin
                in_done = 8'h01 << i;
                out_done = 8'h01 << i;
                in_ok = {NUM_EP{p != 1}};
                in_iso = {NUM_EP{p == 2}};
                out_ok = {NUM_EP{p != 2}};
                out_iso = {NUM_EP{p == 0}};
                cyc(1);
                {in_done, out_done} = 16'h0000;
                cyc(7);
                `CHK(in_st, (p == 0) ? (8'h01 << i) : 8'h00);
                `CHK(out_st, (p == 1) ? (8'h01 << i) : 8'h00);
                `CHK({zero_b, taken}, (p == 2) ? 2'h2 : 2'h1);
                {in_clr, out_clr} = 16'hFFFF;
                cyc(1);
                {in_clr, out_clr} = 16'h0000;
                cyc(2);
                `CHK({zero_b, in_st, out_st}, 17'h10000);
            end
        end
        for (i = 0; i < NUM_BUS_EV; i++) begin
            bus_mask = 7'h7F;
            bus_ev = 7'h01 << i;
            cyc(1);
            bus_ev = 7'h00;
            cyc(2);
            `CHK({zero_b, bus_st}, {1'h1, 7'h01 << i});
            bus_mask = ~(7'h01 << i);
            cyc(3);
            `CHK({zero_b, bus_st}, {1'h0, 7'h01 << i});
            bus_clr = 7'h7F;
            cyc(1);
            bus_clr = 7'h00;
            cyc(2);
            `CHK({zero_b, bus_st}, 8'h80);
        end
        for (i = 0; i < NUM_DREG; i++) begin
            dmask = 4'hF;
            dcond = 4'h1 << i;
            cyc(3);
            `CHK({zero_b, dst, dpend}, {1'h1, 4'h1 << i, 4'h1 << i});
            dmask = 4'h0;
            cyc(3);
            `CHK(zero_b, 1'h0);
            dclr = 4'hF;
            cyc(1);
            dclr = 4'h0;
            cyc(2);
            `CHK({zero_b, dst, dpend}, {1'h1, 4'h1 << i, 4'h0});
            dcond = 4'h0;
            cyc(2);
            `CHK(dst, 4'h0);
        end
        pin_b = 1'h0;
        cyc(4);
        `CHK(zero_b, 1'h1);
        ext_en = 1'h1;
        cyc(4);
        `CHK(zero_b, 1'h0);
        pin_b = 1'h1;
        {one_b_i, t0_i, t1_i, ser_i} = 4'h6;
        cyc(4);
        `CHK({zero_b, one_b, t0_o, t1_o, ser_o}, 5'h16);
        test_done();
    end
endmodule : usb_streaming_irq_aggregator_tb
